// ===== verilog/fsh_regs.svh
`ifndef FSH_REGS_SVH
`define FSH_REGS_SVH
// Opcodes decoded by the erase and power-down sequencer.
`define FSH_OP_WRITE_ENABLE 8'h06
`define FSH_OP_WRITE_DISABLE 8'h04
`define FSH_OP_READ_STATUS 8'h05
`define FSH_OP_SMALL_ERASE 8'h20
`define FSH_OP_LARGE_ERASE_32K 8'h52
`define FSH_OP_LARGE_ERASE_64K 8'hd8
`define FSH_OP_ARRAY_ERASE_A 8'h60
`define FSH_OP_ARRAY_ERASE_B 8'hc7
`define FSH_OP_DEEP_SLEEP 8'hb9
`define FSH_OP_WAKE_ID 8'hab
`define FSH_OP_RESET_ARM 8'h66
`define FSH_OP_RESET_GO 8'h99
// Frame lengths in serial clock bits.
`define FSH_BITS_OPCODE 6'h08
`define FSH_BITS_ADDRESS 6'h20
`define FSH_BITS_MAX 6'h3f
// Erase region sizes as byte masks, and the array size.
`define FSH_SECTOR_MASK 24'h000fff
`define FSH_BLK32_MASK 24'h007fff
`define FSH_BLK64_MASK 24'h00ffff
`define FSH_ARRAY_BYTES 24'h200000
`define FSH_PROT_FINE_UNIT 24'h001000
`define FSH_PROT_COARSE_UNIT 24'h010000
// Status byte field positions and reset value.
`define FSH_STAT_BUSY_POS 0
`define FSH_STAT_WEL_POS 1
`define FSH_STAT_RESET 8'h00
// Timing: clock rate, times in microseconds, derived cycle counts.
`define FSH_CLK_MHZ 10
`define FSH_REGION_ERASE_TIME_US 45000
`define FSH_ARRAY_ERASE_TIME_US 8000000
`define FSH_SLEEP_ENTRY_DELAY_US 3
`define FSH_WAKE_RECOVERY_TIME_US 3
`define FSH_WAKE_ID_RECOVERY_TIME_US 3
`define FSH_REGION_ERASE_CYC (`FSH_REGION_ERASE_TIME_US * `FSH_CLK_MHZ)
`define FSH_ARRAY_ERASE_CYC (`FSH_ARRAY_ERASE_TIME_US * `FSH_CLK_MHZ)
`define FSH_SLEEP_ENTRY_CYC (`FSH_SLEEP_ENTRY_DELAY_US * `FSH_CLK_MHZ)
`define FSH_WAKE_CYC (`FSH_WAKE_RECOVERY_TIME_US * `FSH_CLK_MHZ)
`define FSH_WAKE_ID_CYC (`FSH_WAKE_ID_RECOVERY_TIME_US * `FSH_CLK_MHZ)
`endif

// ===== verilog/fsh_pkg.sv
// Types shared by the erase and power-down sequencer.
package fsh_pkg;
   // Internal operation state, Gray coded along idle, erase, entry, sleep, wake.
   typedef enum logic [2:0] {
      op_idle = 3'b000,
      op_erase = 3'b001,
      op_enter = 3'b011,
      op_sleep = 3'b010,
      op_wake = 3'b110
   } fsh_op_t;
   // Kind of region that an accepted erase covers.
   typedef enum logic [1:0] {
      er_sector = 2'h0,
      er_blk32 = 2'h1,
      er_blk64 = 2'h2,
      er_array = 2'h3
   } fsh_erase_kind_t;
endpackage : fsh_pkg

// ===== verilog/fsh_sync.sv
`timescale 1ns/1ps
// Two-flop synchroniser, one chain for each bit of the bus.
module fsh_sync #(
   parameter int WIDTH = 3,
   parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
   input wire logic clock_i,
   input wire logic rst_i,
   input wire logic [WIDTH-1:0] async_i,
   output logic [WIDTH-1:0] sync_o
);
   genvar gi;
   generate
      for (gi = 0; gi < WIDTH; gi++) begin : g_bit
         logic meta_r; // First stage, read only by the second stage.
         logic meta_nxt;
         logic hold_r; // Second stage, safe to use.
         logic hold_nxt;
         // Next values simply move one stage along.
         always_comb begin
            meta_nxt = async_i[gi];
            hold_nxt = meta_r;
         end
         // Stage registers take their reset constant on reset.
         always_ff @(posedge clock_i) begin
            if (rst_i) begin
               meta_r <= RESET_VAL[gi];
               hold_r <= RESET_VAL[gi];
            end else begin
               meta_r <= meta_nxt;
               hold_r <= hold_nxt;
            end
         end
         assign sync_o[gi] = hold_r;
      end
   endgenerate
endmodule : fsh_sync

// ===== verilog/fsh_erase_pd.sv
`timescale 1ns/1ps
`include "fsh_regs.svh"
// Operation
// - 20H plus address erases its 4KB sector.
// - Address frame: opcode then three address bytes.
// - Erase runs only if select rises after bit 32.
// - Timed region erase keeps busy high until done.
// - Status stays readable while erase runs.
// - Write latch clears before erase completes.
// - Protected region erase is refused, nothing changes.
// - 52H erases its 32KB block likewise.
// - D8H erases its 64KB block likewise.
// - 60H or C7H erase whole array, opcode only.
// - Array erase needs level bits matching complement.
// - B9H enters deep sleep after entry delay.
// - Deep sleep ignores all but wake and reset.
// - Deep sleep request during busy is rejected.
// - Select release without cycle means standby.
// - ABH plus three dummies shifts ID MSB first.
// - ID repeats until select goes high.
// - Wake opcode ignored while busy.
// - Reset pair aborts work, restores power-on state; the code keeps the last erase kind and address.
module fsh_erase_pd
   import fsh_pkg::*;
#(
   parameter logic [7:0] DEVICE_ID = 8'h5a, // Arbitrary neutral identity value.
   parameter int unsigned REGION_ERASE_CYC = `FSH_REGION_ERASE_CYC,
   parameter int unsigned ARRAY_ERASE_CYC = `FSH_ARRAY_ERASE_CYC,
   parameter int unsigned SLEEP_ENTRY_CYC = `FSH_SLEEP_ENTRY_CYC,
   parameter int unsigned WAKE_CYC = `FSH_WAKE_CYC,
   parameter int unsigned WAKE_ID_CYC = `FSH_WAKE_ID_CYC
) (
   input wire logic clock_i,
   input wire logic rst_i,
   input wire logic spi_sck_i,
   input wire logic spi_cs_n_i,
   input wire logic spi_mosi_i,
   output logic spi_miso_o,
   output logic spi_miso_oe_o,
   input wire logic protect_granularity_bit_i,
   input wire logic protect_top_bottom_bit_i,
   input wire logic protect_level_bit2_i,
   input wire logic protect_level_bit1_i,
   input wire logic protect_level_bit0_i,
   input wire logic protect_complement_bit_i,
   output logic busy_o,
   output logic write_enable_latch_o,
   output logic deep_sleep_o,
   output logic erase_start_o,
   output fsh_erase_kind_t erase_kind_o,
   output logic [23:0] erase_addr_o
);

   // Synchronised link pins.
   logic [2:0] sync_w; // Synchronised clock, select and data.
   logic sck_s; // Serial clock in the local domain.
   logic cs_n_s; // Chip select in the local domain, low active.
   logic mosi_s; // Serial data in the local domain.

   // Frame group state.
   logic sck_q_r; // Serial clock one cycle ago.
   logic sck_q_nxt;
   logic cs_q_r; // Chip select one cycle ago.
   logic cs_q_nxt;
   logic [5:0] bit_cnt_r; // Bits taken this frame, saturating.
   logic [5:0] bit_cnt_nxt;
   logic [31:0] shift_r; // Last 32 bits taken, newest in bit 0.
   logic [31:0] shift_nxt;
   logic [7:0] cmd_r; // Opcode of the current frame.
   logic [7:0] cmd_nxt;
   logic [2:0] out_idx_r; // Position within the byte being sent.
   logic [2:0] out_idx_nxt;
   logic miso_r; // Data bit on the output pin.
   logic miso_nxt;
   logic oe_r; // Output pin drive enable.
   logic oe_nxt;

   // Operation group state.
   fsh_op_t op_r; // Internal operation state.
   fsh_op_t op_nxt;
   logic [31:0] timer_r; // Cycles left in the timed phase.
   logic [31:0] timer_nxt;
   logic wel_r; // Write enable latch.
   logic wel_nxt;
   logic armed_r; // Reset-arm frame seen just before.
   logic armed_nxt;
   logic start_r; // One-cycle pulse at erase acceptance.
   logic start_nxt;
   fsh_erase_kind_t kind_r; // Kind of the last accepted erase.
   fsh_erase_kind_t kind_nxt;
   logic [23:0] base_r; // First byte of the last accepted erase.
   logic [23:0] base_nxt;

   // Combinational helpers.
   logic sck_rise; // Rising serial clock edge seen.
   logic sck_fall; // Falling serial clock edge seen.
   logic cs_rise; // Select released: the frame ends.
   logic cs_fall; // Select asserted: a frame begins.
   logic awake; // Not in deep sleep nor waking.
   logic status_mode; // Frame is a status read in output phase.
   logic id_mode; // Frame is an identity read in output phase.
   logic [7:0] status_byte; // Status value sent to the host.
   logic len_op; // Frame ended right after the opcode.
   logic len_addr; // Frame ended right after the address.
   logic [23:0] frame_addr; // Address bytes of the frame.
   logic [2:0] prot_lvl; // Protection level bits.
   logic chip_ok; // Array erase allowed by protection.
   logic [23:0] er_mask; // Byte mask of the addressed region.
   logic [23:0] er_base; // Region start address.
   fsh_erase_kind_t er_kind; // Region kind from the opcode.
   logic region_locked; // Region overlaps the protected area.

   // Tells whether an address falls in the protected area.
   function automatic logic in_locked(input logic [23:0] a, input logic [2:0] lvl,
         input logic fine, input logic top_bot, input logic comp);
      logic [23:0] off;
      logic [23:0] span;
      logic hit;
      off = a & (`FSH_ARRAY_BYTES - 24'h000001);
      span = (fine ? `FSH_PROT_FINE_UNIT : `FSH_PROT_COARSE_UNIT) << (lvl - 3'h1);
      if (lvl == 3'h0) begin
         hit = 1'b0; // Nothing guarded at level zero.
      end else if ((lvl == 3'h7) || (span >= `FSH_ARRAY_BYTES)) begin
         hit = 1'b1; // Guarded area covers the whole array.
      end else if (top_bot) begin
         hit = off < span; // Guarded area grows from the bottom.
      end else begin
         hit = off >= (`FSH_ARRAY_BYTES - span); // Guarded area grows from the top.
      end
      return hit ^ comp;
   endfunction : in_locked

   // Every link pin passes two flops; select idles high.
   fsh_sync #(
      .WIDTH(3),
      .RESET_VAL(3'h2)
   ) u_sync (
      .clock_i(clock_i),
      .rst_i(rst_i),
      .async_i({spi_mosi_i, spi_cs_n_i, spi_sck_i}),
      .sync_o(sync_w)
   );
   assign sck_s = sync_w[0];
   assign cs_n_s = sync_w[1];
   assign mosi_s = sync_w[2];

   // Edge detection on the synchronised pins.
   assign sck_rise = sck_s & ~sck_q_r;
   assign sck_fall = ~sck_s & sck_q_r;
   assign cs_rise = cs_n_s & ~cs_q_r;
   assign cs_fall = ~cs_n_s & cs_q_r;

   // Output phase decode for the two reading frames.
   assign awake = (op_r != op_sleep) && (op_r != op_wake);
   always_comb begin
      status_byte = `FSH_STAT_RESET;
      status_byte[`FSH_STAT_BUSY_POS] = op_r == op_erase;
      status_byte[`FSH_STAT_WEL_POS] = wel_r;
   end
   assign status_mode = awake && (cmd_r == `FSH_OP_READ_STATUS) &&
      (bit_cnt_r >= `FSH_BITS_OPCODE);
   assign id_mode = ((op_r == op_idle) || (op_r == op_sleep)) &&
      (cmd_r == `FSH_OP_WAKE_ID) && (bit_cnt_r >= `FSH_BITS_ADDRESS);

   // Frame group: shifts bits in, counts them and drives the output pin.
   always_comb begin
      sck_q_nxt = sck_s;
      cs_q_nxt = cs_n_s;
      bit_cnt_nxt = bit_cnt_r;
      shift_nxt = shift_r;
      cmd_nxt = cmd_r;
      out_idx_nxt = out_idx_r;
      miso_nxt = miso_r;
      oe_nxt = oe_r;
      if (cs_fall) begin
         // A new frame starts with a clean count and no opcode.
         bit_cnt_nxt = 6'h00;
         out_idx_nxt = 3'h0;
         cmd_nxt = 8'h00;
      end else if (cs_n_s) begin
         // Deselected: release the output pin.
         oe_nxt = 1'b0;
      end else begin
         if (sck_rise) begin
            // Take one bit, most significant first.
            shift_nxt = {shift_r[30:0], mosi_s};
            if (bit_cnt_r != `FSH_BITS_MAX) begin
               bit_cnt_nxt = bit_cnt_r + 6'h01;
            end
            if (bit_cnt_r == (`FSH_BITS_OPCODE - 6'h01)) begin
               cmd_nxt = {shift_r[6:0], mosi_s};
            end
         end
         if (sck_fall && (status_mode || id_mode)) begin
            // Send the next bit on the falling edge, wrapping each byte.
            oe_nxt = 1'b1;
            if (status_mode) begin
               miso_nxt = status_byte[3'h7 - out_idx_r];
            end else begin
               miso_nxt = DEVICE_ID[3'h7 - out_idx_r];
            end
            out_idx_nxt = out_idx_r + 3'h1;
         end
      end
   end

   // Frame group registers.
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         sck_q_r <= 1'b0;
         cs_q_r <= 1'b1;
         bit_cnt_r <= 6'h00;
         shift_r <= 32'h00000000;
         cmd_r <= 8'h00;
         out_idx_r <= 3'h0;
         miso_r <= 1'b0;
         oe_r <= 1'b0;
      end else begin
         sck_q_r <= sck_q_nxt;
         cs_q_r <= cs_q_nxt;
         bit_cnt_r <= bit_cnt_nxt;
         shift_r <= shift_nxt;
         cmd_r <= cmd_nxt;
         out_idx_r <= out_idx_nxt;
         miso_r <= miso_nxt;
         oe_r <= oe_nxt;
      end
   end

   // Frame length checks and protection inputs.
   assign len_op = bit_cnt_r == `FSH_BITS_OPCODE;
   assign len_addr = bit_cnt_r == `FSH_BITS_ADDRESS;
   assign frame_addr = shift_r[23:0];
   assign prot_lvl = {protect_level_bit2_i, protect_level_bit1_i, protect_level_bit0_i};
   assign chip_ok = ((prot_lvl == 3'h0) && !protect_complement_bit_i) ||
      ((prot_lvl == 3'h7) && protect_complement_bit_i);

   // Region size and kind follow the opcode.
   always_comb begin
      case (cmd_r)
         `FSH_OP_LARGE_ERASE_32K: begin
            er_mask = `FSH_BLK32_MASK;
            er_kind = er_blk32;
         end
         `FSH_OP_LARGE_ERASE_64K: begin
            er_mask = `FSH_BLK64_MASK;
            er_kind = er_blk64;
         end
         default: begin
            er_mask = `FSH_SECTOR_MASK;
            er_kind = er_sector;
         end
      endcase
   end
   assign er_base = frame_addr & ~er_mask;
   // Both ends of the region are checked against the guarded area.
   assign region_locked = in_locked(er_base, prot_lvl, protect_granularity_bit_i,
      protect_top_bottom_bit_i, protect_complement_bit_i) ||
      in_locked(er_base | er_mask, prot_lvl, protect_granularity_bit_i,
      protect_top_bottom_bit_i, protect_complement_bit_i);

   // Operation group: timed phases, then the decode of each finished frame.
   always_comb begin
      op_nxt = op_r;
      timer_nxt = timer_r;
      wel_nxt = wel_r;
      armed_nxt = armed_r;
      start_nxt = 1'b0;
      kind_nxt = kind_r;
      base_nxt = base_r;
      case (op_r)
         op_erase, op_enter, op_wake: begin
            // Count the timed phase down and leave it at the end.
            if (timer_r > 32'h00000001) begin
               timer_nxt = timer_r - 32'h00000001;
            end else begin
               timer_nxt = 32'h00000000;
               op_nxt = (op_r == op_enter) ? op_sleep : op_idle;
            end
         end
         op_idle, op_sleep: begin
            timer_nxt = 32'h00000000;
         end
         default: begin
            op_nxt = op_idle;
         end
      endcase
      if (cs_rise) begin
         // Only a reset-arm frame of exact length arms the reset.
         armed_nxt = len_op && (cmd_r == `FSH_OP_RESET_ARM);
         if (len_op && (cmd_r == `FSH_OP_RESET_GO) && armed_r) begin
            // Abort all work and clear the latch; the last erase kind and base stay.
            op_nxt = op_idle;
            timer_nxt = 32'h00000000;
            wel_nxt = 1'b0;
         end else if (op_r == op_idle) begin
            // Standby: decode the finished frame.
            case (cmd_r)
               `FSH_OP_WRITE_ENABLE: begin
                  if (len_op) begin
                     wel_nxt = 1'b1;
                  end
               end
               `FSH_OP_WRITE_DISABLE: begin
                  if (len_op) begin
                     wel_nxt = 1'b0;
                  end
               end
               `FSH_OP_SMALL_ERASE, `FSH_OP_LARGE_ERASE_32K, `FSH_OP_LARGE_ERASE_64K: begin
                  // Exact length, latch set, region not guarded.
                  if (len_addr && wel_r && !region_locked) begin
                     op_nxt = op_erase;
                     timer_nxt = 32'(REGION_ERASE_CYC);
                     wel_nxt = 1'b0;
                     start_nxt = 1'b1;
                     kind_nxt = er_kind;
                     base_nxt = er_base;
                  end
               end
               `FSH_OP_ARRAY_ERASE_A, `FSH_OP_ARRAY_ERASE_B: begin
                  // Opcode-only frame, latch set, protection permits.
                  if (len_op && wel_r && chip_ok) begin
                     op_nxt = op_erase;
                     timer_nxt = 32'(ARRAY_ERASE_CYC);
                     wel_nxt = 1'b0;
                     start_nxt = 1'b1;
                     kind_nxt = er_array;
                     base_nxt = 24'h000000;
                  end
               end
               `FSH_OP_DEEP_SLEEP: begin
                  if (len_op) begin
                     op_nxt = op_enter;
                     timer_nxt = 32'(SLEEP_ENTRY_CYC);
                  end
               end
               default: begin
                  wel_nxt = wel_r;
               end
            endcase
         end else if (op_r == op_sleep) begin
            // Deep sleep: besides the reset pair, only the wake opcode leaves it.
            if ((cmd_r == `FSH_OP_WAKE_ID) && (bit_cnt_r >= `FSH_BITS_OPCODE)) begin
               op_nxt = op_wake;
               timer_nxt = len_op ? 32'(WAKE_CYC) : 32'(WAKE_ID_CYC);
            end
         end
         // In erase, entry or wake every other frame is dropped.
      end
   end

   // Operation group registers.
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         op_r <= op_idle;
         timer_r <= 32'h00000000;
         wel_r <= 1'b0;
         armed_r <= 1'b0;
         start_r <= 1'b0;
         kind_r <= er_sector;
         base_r <= 24'h000000;
      end else begin
         op_r <= op_nxt;
         timer_r <= timer_nxt;
         wel_r <= wel_nxt;
         armed_r <= armed_nxt;
         start_r <= start_nxt;
         kind_r <= kind_nxt;
         base_r <= base_nxt;
      end
   end

   // Outputs, all decoded from registers.
   assign spi_miso_o = miso_r;
   assign spi_miso_oe_o = oe_r;
   assign busy_o = op_r == op_erase;
   assign write_enable_latch_o = wel_r;
   assign deep_sleep_o = op_r == op_sleep;
   assign erase_start_o = start_r;
   assign erase_kind_o = kind_r;
   assign erase_addr_o = base_r;
endmodule : fsh_erase_pd

// ===== verif/fsh_erase_pd_checker.sv
`timescale 1ns/1ps
// Port-level checks of the sequencer.
module fsh_erase_pd_checker
   import fsh_pkg::*;
#(
   parameter int unsigned REGION_ERASE_CYC = 50,
   parameter int unsigned ARRAY_ERASE_CYC = 80
) (
   input wire logic clock_i,
   input wire logic rst_i,
   input wire logic spi_cs_n_i,
   input wire logic spi_miso_oe_o,
   input wire logic busy_o,
   input wire logic write_enable_latch_o,
   input wire logic deep_sleep_o,
   input wire logic erase_start_o,
   input wire fsh_erase_kind_t erase_kind_o,
   input wire logic [23:0] erase_addr_o
);
   logic [31:0] busy_cnt_r; // Busy stretch length.
   logic [31:0] busy_cnt_nxt; // Next count.
   logic [31:0] busy_lim; // Allowed stretch.
   logic [23:0] base_mask; // Bits clear in a base.
   // Count busy cycles.
   always_comb begin
      busy_cnt_nxt = busy_o ? busy_cnt_r + 32'h1 : 32'h0;
   end
   // Count register.
   always_ff @(posedge clock_i) begin
      busy_cnt_r <= rst_i ? 32'h0 : busy_cnt_nxt;
   end
   assign busy_lim = (erase_kind_o == er_array) ? ARRAY_ERASE_CYC : REGION_ERASE_CYC;
   assign base_mask = (erase_kind_o == er_sector) ? 24'h000fff :
      (erase_kind_o == er_blk32) ? 24'h007fff : 24'h00ffff;
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (rst_i);
   // Acceptance cycle.
   sequence s_launch;
      erase_start_o && busy_o && !write_enable_latch_o;
   endsequence
   // Cycle after acceptance.
   sequence s_running;
      ##1 (!erase_start_o && busy_o && !write_enable_latch_o);
   endsequence
   AST_START_LAUNCH: assert property (erase_start_o |-> s_launch)
      else $error("bad launch");
   AST_START_RUN: assert property (erase_start_o |-> s_running)
      else $error("no run after start");
   AST_START_WEL: assert property (erase_start_o |-> $past(write_enable_latch_o))
      else $error("start without latch");
   AST_START_CS: assert property (erase_start_o |-> $past(spi_cs_n_i, 2))
      else $error("start with select low");
   AST_BUSY_RISE: assert property ($rose(busy_o) |-> erase_start_o)
      else $error("busy without start");
   AST_BUSY_BOUND: assert property (busy_o |-> busy_cnt_r < busy_lim)
      else $error("busy too long");
   AST_BUSY_AWAKE: assert property (busy_o |-> !deep_sleep_o)
      else $error("sleep while busy");
   AST_SLEEP_NO_ERASE: assert property (deep_sleep_o |-> !erase_start_o)
      else $error("start in sleep");
   AST_ARRAY_BASE: assert property (erase_start_o && erase_kind_o == er_array
      |-> erase_addr_o == 24'h0)
      else $error("array base");
   AST_BASE_ALIGN: assert property (erase_start_o && erase_kind_o != er_array
      |-> (erase_addr_o & base_mask) == 24'h0)
      else $error("base unaligned");
   AST_OE_RELEASE: assert property (spi_cs_n_i [*5] |-> !spi_miso_oe_o)
      else $error("oe with select high");
endmodule : fsh_erase_pd_checker

bind fsh_erase_pd fsh_erase_pd_checker #(
   .REGION_ERASE_CYC(REGION_ERASE_CYC), .ARRAY_ERASE_CYC(ARRAY_ERASE_CYC)
) u_fsh_erase_pd_checker (.clock_i(clock_i), .rst_i(rst_i), .spi_cs_n_i(spi_cs_n_i),
   .spi_miso_oe_o(spi_miso_oe_o), .busy_o(busy_o), .write_enable_latch_o(write_enable_latch_o),
   .deep_sleep_o(deep_sleep_o), .erase_start_o(erase_start_o), .erase_kind_o(erase_kind_o),
   .erase_addr_o(erase_addr_o));

// ===== verif/fsh_host_model.sv
`timescale 1ns/1ps
// Host: mode 0, MSB first, clock idle low.
module fsh_host_model (
   output logic spi_sck_o,
   output logic spi_cs_n_o,
   output logic spi_mosi_o,
   input wire logic spi_miso_i,
   input wire logic spi_miso_oe_i
);
   localparam int HALF_NS = 400; // Half of 800 ns.
   // Idle link.
   initial begin
      spi_sck_o = 1'b0;
      spi_cs_n_o = 1'b1;
      spi_mosi_o = 1'b0;
   end
   // Sends low n bits of v; rx is the last byte read.
   task automatic frame(input logic [47:0] v, input int n, output logic [7:0] rx);
      rx = 8'h00;
      spi_cs_n_o = 1'b0;
      for (int i = n - 1; i >= 0; i--) begin
         spi_mosi_o = v[i];
         #(HALF_NS);
         spi_sck_o = 1'b1;
         rx = {rx[6:0], spi_miso_oe_i ? spi_miso_i : 1'bx};
         #(HALF_NS);
         spi_sck_o = 1'b0;
      end
      #(HALF_NS);
      spi_cs_n_o = 1'b1;
      // Released data line shows the inverse.
      spi_mosi_o = ~spi_mosi_o;
      #(4 * HALF_NS);
   endtask : frame
endmodule : fsh_host_model

// ===== verif/testbench.sv
`timescale 1ns/1ps
// Self-checking bench of the sequencer.
module testbench;
   import fsh_pkg::*;
   localparam int REGION_CYC = 800;
   localparam int ARRAY_CYC = 900;
   localparam logic [7:0] ID_VAL = 8'h3c; // Arbitrary identity value.
   // One erase attempt.
   typedef struct {
      logic [7:0] op;
      logic [23:0] addr;
      int nb;
      logic [5:0] prot; // {granularity, top_bottom, level2..0, complement}
      logic wen;
      logic ok;
      fsh_erase_kind_t kind;
      logic [23:0] base;
   } fsh_row_t;
   fsh_row_t rows [12] = '{
      '{8'h20, 24'h123456, 32, 6'h00, 1, 1, er_sector, 24'h123000},
      '{8'h52, 24'h0abcde, 32, 6'h00, 1, 1, er_blk32, 24'h0a8000},
      '{8'hd8, 24'h1fffff, 32, 6'h00, 1, 1, er_blk64, 24'h1f0000},
      '{8'h60, 24'h000000, 8, 6'h00, 1, 1, er_array, 24'h000000},
      '{8'hc7, 24'h000000, 8, 6'h0f, 1, 1, er_array, 24'h000000},
      '{8'hc7, 24'h000000, 8, 6'h0e, 1, 0, er_sector, 24'h000000},
      '{8'h60, 24'h000000, 8, 6'h02, 1, 0, er_sector, 24'h000000},
      '{8'h20, 24'h1ff000, 32, 6'h02, 1, 0, er_sector, 24'h000000},
      '{8'h20, 24'h000abc, 32, 6'h02, 1, 1, er_sector, 24'h000000},
      '{8'hd8, 24'h050000, 31, 6'h00, 1, 0, er_sector, 24'h000000},
      '{8'h20, 24'h050000, 33, 6'h00, 1, 0, er_sector, 24'h000000},
      '{8'h20, 24'h050000, 32, 6'h00, 0, 0, er_sector, 24'h000000}};
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic [5:0] prot = 6'h00;
   logic sck, cs_n, mosi, miso, miso_oe, busy, write_enable_latch, sleep, start;
   fsh_erase_kind_t kind;
   logic [23:0] base_addr;
   logic [7:0] rx_byte; // Last byte read.
   int error_cnt = 0;
   int comparisons = 0;
   int start_cnt = 0; // Accepted erases seen.
   int busy_run = 0; // Busy run.
   int last_run = 0; // Last busy run.
   int cyc = 0; // Hang limit count.
   int n0;
   fsh_erase_pd #(.DEVICE_ID(ID_VAL), .REGION_ERASE_CYC(REGION_CYC), .ARRAY_ERASE_CYC(ARRAY_CYC),
      .SLEEP_ENTRY_CYC(5), .WAKE_CYC(5), .WAKE_ID_CYC(7)) u_fsh_erase_pd (.clock_i(clock),
      .rst_i(rst), .spi_sck_i(sck), .spi_cs_n_i(cs_n), .spi_mosi_i(mosi), .spi_miso_o(miso),
      .spi_miso_oe_o(miso_oe), .protect_granularity_bit_i(prot[5]),
      .protect_top_bottom_bit_i(prot[4]), .protect_level_bit2_i(prot[3]),
      .protect_level_bit1_i(prot[2]), .protect_level_bit0_i(prot[1]),
      .protect_complement_bit_i(prot[0]), .busy_o(busy), .write_enable_latch_o(write_enable_latch),
      .deep_sleep_o(sleep), .erase_start_o(start), .erase_kind_o(kind),
      .erase_addr_o(base_addr));
   fsh_host_model u_fsh_host_model (.spi_sck_o(sck), .spi_cs_n_o(cs_n), .spi_mosi_o(mosi),
      .spi_miso_i(miso), .spi_miso_oe_i(miso_oe));
   // System clock, 100 ns period.
   initial begin
      forever #50 clock = ~clock;
   end
   // Monitor and hang limit.
   always @(posedge clock) begin
      cyc <= cyc + 1;
      if (start === 1'b1) start_cnt <= start_cnt + 1;
      if (busy === 1'b1) busy_run <= busy_run + 1;
      else if (busy_run != 0) begin
         last_run <= busy_run;
         busy_run <= 0;
      end
      if (cyc == 40000) begin
         error_cnt++;
         give_verdict();
      end
   end
   // Verdict, then end.
   task automatic give_verdict();
      $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : give_verdict
   // Compares one flag.
   task automatic chk_bit(input string what, input logic exp, input logic got);
      comparisons++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] %s expected %b seen %b", what, exp, got);
      end
   endtask : chk_bit
   // Compares a value.
   task automatic chk_val(input string what, input logic [23:0] exp, input logic [23:0] got);
      comparisons++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask : chk_val
   // One frame after a clock edge.
   task automatic send(input logic [47:0] v, input int n);
      @(posedge clock);
      #7;
      u_fsh_host_model.frame(v, n, rx_byte);
   endtask : send
   // Bounded wait for erase end.
   task automatic wait_idle();
      for (int n = 0; n < 2000 && busy !== 1'b0; n++) @(posedge clock);
      chk_bit("busy end", 1'b0, busy);
      @(posedge clock);
      #1;
   endtask : wait_idle
   // Reset, table, then hand cases.
   initial begin
      repeat (8) @(posedge clock);
      #7 rst = 1'b0;
      chk_bit("busy", 1'b0, busy);
      chk_bit("latch", 1'b0, write_enable_latch);
      chk_bit("sleep", 1'b0, sleep);
      chk_bit("out enable", 1'b0, miso_oe);
      foreach (rows[i]) begin
         @(posedge clock);
         #7 prot = rows[i].prot;
         send(48'h04, 8);
         if (rows[i].wen) send(48'h06, 8);
         chk_bit("latch set", rows[i].wen, write_enable_latch);
         n0 = start_cnt;
         send({rows[i].op, rows[i].addr, 16'h0} >> (48 - rows[i].nb), rows[i].nb);
         chk_val("accepted", 24'(rows[i].ok), 24'(start_cnt - n0));
         if (rows[i].ok) begin
            chk_val("kind", 24'(rows[i].kind), 24'(kind));
            chk_val("base", rows[i].base, base_addr);
            chk_bit("latch cleared", 1'b0, write_enable_latch);
            wait_idle();
            chk_val("busy length", 24'(rows[i].kind == er_array ? ARRAY_CYC : REGION_CYC),
               24'(last_run));
         end else begin
            chk_bit("latch kept", rows[i].wen, write_enable_latch);
            chk_bit("no busy", 1'b0, busy);
         end
      end
      @(posedge clock);
      #7 prot = 6'h00;
      send(48'h06, 8);
      send({16'h0, 8'h20, 24'h004000}, 32);
      send(48'h0500, 16);
      chk_val("status in erase", 24'h01, 24'(rx_byte));
      send(48'hb9, 8);
      send({8'hab, 40'h0}, 48);
      chk_bit("still busy", 1'b1, busy);
      wait_idle();
      chk_val("busy length", 24'(REGION_CYC), 24'(last_run));
      chk_bit("no sleep", 1'b0, sleep);
      send(48'hb9, 8);
      chk_bit("sleep", 1'b1, sleep);
      n0 = start_cnt;
      send(48'h06, 8);
      send({16'h0, 8'h20, 24'h0}, 32);
      chk_val("erase in sleep", 24'h0, 24'(start_cnt - n0));
      chk_bit("latch in sleep", 1'b0, write_enable_latch);
      send({8'hab, 40'h0}, 48);
      chk_val("id repeat", 24'(ID_VAL), 24'(rx_byte));
      chk_bit("awake", 1'b0, sleep);
      send(48'h0500, 16);
      chk_val("status standby", 24'h00, 24'(rx_byte));
      for (int k = 0; k < 2; k++) begin
         send(48'hb9, 8);
         chk_bit("sleep", 1'b1, sleep);
         send(k == 0 ? 48'hab : 48'h66, 8);
         if (k == 1) send(48'h99, 8);
         chk_bit("woken", 1'b0, sleep);
      end
      send({8'hab, 32'h0}, 40);
      chk_val("id standby", 24'(ID_VAL), 24'(rx_byte));
      give_verdict();
   end
endmodule : testbench
